//--- verilog/sde_config_regs.sv
// Configuration register bank of the standard-definition video encoder
`timescale 1ns/1ps
module sde_config_regs
  import sde_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Serial control port
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // External timing inputs
  input  wire logic        lineSyncN,
  input  wire logic        fieldSyncN,
  // Reset to the encoder core
  output logic             encoderReset,
  // Power control
  output logic [2:0]       dacEnable,
  output logic             pllEnable,
  // Input selection
  output logic [2:0]       inputMode,
  output logic             rgbInput,
  output logic             wideInputBus,
  output logic             rgb16Input,
  // Output selection
  output logic             rgbOutput,
  output logic             rgbSyncEmbed,
  output logic             componentOutput,
  output logic             compositeVideoOutput,
  // Standard and filters
  output logic             palStandard,
  output logic             lumaShapingFilter,
  output logic [2:0]       chromaFilterSel,
  output logic             colourDiffShapingFilter,
  output logic             activeEdgeControl,
  output logic             pedestalEnable,
  output logic             squarePixel,
  output logic             pixelDataValid,
  // Timing
  output logic [1:0]       timingMode,
  output logic             timingSlave,
  output logic             lineStart,
  output logic             fieldStart,
  // Subcarrier frequency
  output logic [31:0]      subcarrierFreq
);

  // ==========================================================================
  // Storage and port wiring
  logic [7:0] regFile [REG_COUNT];
  logic       wrStrobe;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  logic       softBusy;
  logic       lineSyncPrev;
  logic       fieldSyncPrev;

  // Serial slave; it shares no clock with the host beyond sampled pins
  sde_serial_port #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .scl      (scl),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe),
    .wrStrobe (wrStrobe),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .rdAddr   (rdAddr),
    .rdData   (rdData)
  );

  // ==========================================================================
  // Software reset
  // Only the reset bit is acted on; other bits of this register are plain storage
  wire softStart = wrStrobe & (wrAddr == REG_OFFSET[IDX_SWRESET])
                 & wrData[BIT_SWRESET];

  sde_reset_pulse #(
    .LENGTH (SOFT_RESET_CYCLES)
  ) u_reset (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (softStart),
    .busy    (softBusy)
  );

  assign encoderReset = softBusy;

  // ==========================================================================
  // Register file
  // Writes that arrive during the software reset are dropped so the
  // bank comes out of reset in a known state; host must wait it out
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
      wire hit = wrStrobe & (wrAddr == REG_OFFSET[gi]);
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          regFile[gi] <= REG_RESET_VALUE;
        end else if (softBusy) begin
          regFile[gi] <= REG_RESET_VALUE;
        end else if (hit) begin
          regFile[gi] <= wrData;
        end
      end
    end
  endgenerate

  // Read decode; unmapped subaddresses read as zero
  always_comb begin
    rdData = 8'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (rdAddr == REG_OFFSET[i]) begin
        rdData = regFile[i];
      end
    end
  end

  // ==========================================================================
  // Power and input mode fields
  wire [7:0] powerReg   = regFile[IDX_POWER];
  wire [7:0] inModeReg  = regFile[IDX_INMODE];
  wire [7:0] outFmtReg  = regFile[IDX_OUTFMT];
  wire [7:0] stdReg     = regFile[IDX_STD];
  wire [7:0] outCtlReg  = regFile[IDX_OUTCTL];
  wire [7:0] inColorReg = regFile[IDX_INCOLOR];
  wire [7:0] inWidthReg = regFile[IDX_INWIDTH];
  wire [7:0] timingReg  = regFile[IDX_TIMING];

  // PLL bit is a power-down, so a zero keeps the 16x multiplier running
  assign dacEnable = powerReg[BIT_DAC_LO +: 3];
  assign pllEnable = ~powerReg[BIT_PLL_OFF];

  // Zero in the mode field is standard definition
  assign inputMode = inModeReg[BIT_INMODE_LO +: 3];

  // ==========================================================================
  // Input colour space and width
  assign rgbInput     = inColorReg[BIT_RGB_IN];
  assign wideInputBus = inWidthReg[BIT_WIDE_BUS];
  // Sixteen-bit RGB needs both the wide bus and RGB input
  assign rgb16Input   = wideInputBus & rgbInput;

  // ==========================================================================
  // Output format
  // One bit both selects RGB and puts sync on the RGB outputs
  assign rgbOutput    = outFmtReg[BIT_RGB_OUT];
  assign rgbSyncEmbed = outFmtReg[BIT_RGB_OUT];

  // Component versus composite plus separate luma/chroma
  assign compositeVideoOutput = outCtlReg[BIT_COMPOSITE];
  assign componentOutput      = ~outCtlReg[BIT_COMPOSITE];

  // ==========================================================================
  // Standard and filters
  assign palStandard       = stdReg[BIT_PAL];
  assign lumaShapingFilter = stdReg[BIT_LUMA_SHAPE];
  // Code zero picks the 1.3 MHz chroma low-pass response
  assign chromaFilterSel   = stdReg[BIT_CHROMA_LO +: 3];

  // Output control bits; 0xC1, 0xC3 and 0xD3 differ only in bits 1 and 4
  assign pixelDataValid          = outCtlReg[BIT_PIX_VALID];
  assign colourDiffShapingFilter = outCtlReg[BIT_CDIFF_SHAPE];
  assign activeEdgeControl       = outCtlReg[BIT_EDGE_CTL];
  assign pedestalEnable          = outCtlReg[BIT_PEDESTAL];
  assign squarePixel             = outCtlReg[BIT_SQUARE_PIX];

  // ==========================================================================
  // Timing mode
  assign timingMode  = timingReg[BIT_TMODE_LO +: 2];
  // Slave when the master bit is clear and the external sync inputs are enabled
  assign timingSlave = ~timingReg[BIT_MASTER] & timingReg[BIT_EXT_SYNC];

  wire followSync = timingSlave & (timingMode == TIMING_MODE_2);

  // Edge history of the sync pins; idle high since they are active low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lineSyncPrev  <= 1'b1;
      fieldSyncPrev <= 1'b1;
    end else begin
      lineSyncPrev  <= lineSyncN;
      fieldSyncPrev <= fieldSyncN;
    end
  end

  // Falling edges mark line and field starts; ignored unless slaved in timing mode 2, and ignored during software reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lineStart  <= 1'b0;
      fieldStart <= 1'b0;
    end else begin
      lineStart  <= followSync & ~softBusy & lineSyncPrev & ~lineSyncN;
      fieldStart <= followSync & ~softBusy & fieldSyncPrev & ~fieldSyncN;
    end
  end

  // ==========================================================================
  // Subcarrier frequency word, byte 0 least significant
  // The four bytes are loaded one by one; the word is only coherent once the
  // host has written all four, so it should do so before enabling video
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      subcarrierFreq <= 32'h0000_0000;
    end else begin
      subcarrierFreq <= {regFile[IDX_FSC0 + 3], regFile[IDX_FSC0 + 2],
                         regFile[IDX_FSC0 + 1], regFile[IDX_FSC0]};
    end
  end

endmodule // sde_config_regs

//--- inc/sde_pkg.sv
// Shared constants for the standard-definition encoder configuration registers
// ==========================================================================
// Overview of operation
// - Writing 0x02 to subaddress 0x17 starts a software reset of the encoder.
// - Writing 0x1C to subaddress 0x00 enables all output DACs and the 16x oversampling PLL.
// - Writing 0x00 to subaddress 0x01 selects standard-definition input mode.
// - Writing 0x11 to subaddress 0x80 selects PAL, the luma shaping filter and the 1.3 MHz chroma filter.
// - Writing 0xC1 to subaddress 0x82 marks pixel data valid, selects component output, colour-difference filter and edge control.
// - Writing 0xC3 to subaddress 0x82 keeps those settings but selects composite plus separate luma/chroma output.
// - Writing 0xD3 to subaddress 0x82 does as 0xC3 and also enables square-pixel operation.
// - Writing 0x10 to subaddress 0x02 switches component outputs to RGB with sync embedded on them.
// - Writing 0x80 to subaddress 0x87 makes the encoder take RGB instead of luma/colour-difference input.
// - Writing 0x10 to subaddress 0x88 enables the wide input bus, giving 16-bit RGB when RGB input is selected.
// - Writing 0x0C to subaddress 0x8A makes the encoder a timing mode 2 slave following external line and field syncs.
package sde_pkg;

  // ==========================================================================
  // Register map
  localparam int REG_COUNT = 13;
  localparam logic [7:0] REG_OFFSET [REG_COUNT] = '{
    8'h00, 8'h01, 8'h02, 8'h17, 8'h80, 8'h82, 8'h87,
    8'h88, 8'h8A, 8'h8C, 8'h8D, 8'h8E, 8'h8F};
  localparam int IDX_POWER   = 0;
  localparam int IDX_INMODE  = 1;
  localparam int IDX_OUTFMT  = 2;
  localparam int IDX_SWRESET = 3;
  localparam int IDX_STD     = 4;
  localparam int IDX_OUTCTL  = 5;
  localparam int IDX_INCOLOR = 6;
  localparam int IDX_INWIDTH = 7;
  localparam int IDX_TIMING  = 8;
  localparam int IDX_FSC0    = 9;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int BIT_SWRESET     = 1;
  localparam int BIT_PLL_OFF     = 1;
  localparam int BIT_DAC_LO      = 2;
  localparam int BIT_INMODE_LO   = 4;
  localparam int BIT_RGB_OUT     = 4;
  localparam int BIT_PAL         = 0;
  localparam int BIT_LUMA_SHAPE  = 4;
  localparam int BIT_CHROMA_LO   = 5;
  localparam int BIT_PIX_VALID   = 0;
  localparam int BIT_COMPOSITE   = 1;
  localparam int BIT_PEDESTAL    = 3;
  localparam int BIT_SQUARE_PIX  = 4;
  localparam int BIT_CDIFF_SHAPE = 6;
  localparam int BIT_EDGE_CTL    = 7;
  localparam int BIT_RGB_IN      = 7;
  localparam int BIT_WIDE_BUS    = 4;
  localparam int BIT_MASTER      = 0;
  localparam int BIT_TMODE_LO    = 1;
  localparam int BIT_EXT_SYNC    = 3;
  localparam logic [1:0] TIMING_MODE_2 = 2'h2;

  // ==========================================================================
  // Timing
  localparam int SOFT_RESET_CYCLES = 8;

endpackage : sde_pkg

//--- verilog/sde_reset_pulse.sv
// Stretches a one-cycle software reset request into a fixed-length level
`timescale 1ns/1ps
module sde_reset_pulse
  import sde_pkg::*;
#(
  parameter int LENGTH = SOFT_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Request and level
  input  wire logic start,
  output logic      busy
);

  logic [7:0] count;

  // A request while busy restarts the count so the reset always lasts the full length
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 8'h00;
    end else if (start) begin
      count <= 8'(LENGTH);
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  assign busy = (count != 8'h00);

endmodule // sde_reset_pulse

//--- verilog/sde_serial_port.sv
// Serial control port slave: device address, subaddress pointer, byte writes and reads
`timescale 1ns/1ps
module sde_serial_port
  import sde_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Serial pins
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Register side
  output logic            wrStrobe,
  output logic [7:0]      wrAddr,
  output logic [7:0]      wrData,
  output logic [7:0]      rdAddr,
  input  wire logic [7:0] rdData
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_SUB, ST_ACK_SUB,
    ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_RACK
  } sde_port_state_t;

  sde_port_state_t state;
  logic       sclPrev;
  logic       sdaPrev;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg;
  logic [7:0] txReg;
  logic [7:0] pointer;
  logic       ackDrive;
  logic       readDir;
  logic       hostAck;

  // Bus conditions from the previous sample
  wire sclRise   = scl & ~sclPrev;
  wire sclFall   = ~scl & sclPrev;
  wire startCond = scl & sclPrev & sdaPrev & ~sdaIn;
  wire stopCond  = scl & sclPrev & ~sdaPrev & sdaIn;
  wire byteIn    = (bitCnt == 4'h8);
  wire addrHit   = (shiftReg[7:1] == DEV_ADDR);

  // Open drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe  = ackDrive | ((state == ST_RDATA) & ~txReg[7]);
  assign rdAddr = pointer;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= scl;
      sdaPrev <= sdaIn;
    end
  end

  // Byte engine; bits shift in on rising SCL, drive changes on falling SCL
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= ST_IDLE;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      txReg    <= 8'h00;
      pointer  <= 8'h00;
      ackDrive <= 1'b0;
      readDir  <= 1'b0;
      hostAck  <= 1'b0;
      wrStrobe <= 1'b0;
      wrAddr   <= 8'h00;
      wrData   <= 8'h00;
    end else begin
      wrStrobe <= 1'b0;
      if (startCond) begin
        state    <= ST_ADDR;
        bitCnt   <= 4'h0;
        ackDrive <= 1'b0;
      end else if (stopCond) begin
        state    <= ST_IDLE;
        ackDrive <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
          end
          ST_ADDR, ST_SUB, ST_WDATA: begin
            if (sclRise && !byteIn) begin
              shiftReg <= {shiftReg[6:0], sdaIn};
              bitCnt   <= bitCnt + 4'h1;
            end else if (sclFall && byteIn) begin
              bitCnt <= 4'h0;
              if (state == ST_ADDR) begin
                ackDrive <= addrHit;
                readDir  <= shiftReg[0];
                state    <= addrHit ? ST_ACK_ADDR : ST_IDLE;
              end else if (state == ST_SUB) begin
                pointer  <= shiftReg;
                ackDrive <= 1'b1;
                state    <= ST_ACK_SUB;
              end else begin
                wrStrobe <= 1'b1;
                wrAddr   <= pointer;
                wrData   <= shiftReg;
                pointer  <= pointer + 8'h01;
                ackDrive <= 1'b1;
                state    <= ST_ACK_WDATA;
              end
            end
          end
          ST_ACK_ADDR, ST_ACK_SUB, ST_ACK_WDATA: begin
            if (sclFall) begin
              ackDrive <= 1'b0;
              if (state == ST_ACK_ADDR && readDir) begin
                txReg <= rdData;
                state <= ST_RDATA;
              end else if (state == ST_ACK_ADDR) begin
                state <= ST_SUB;
              end else begin
                state <= ST_WDATA;
              end
            end
          end
          ST_RDATA: begin
            if (sclFall) begin
              txReg  <= {txReg[6:0], 1'b1};
              bitCnt <= bitCnt + 4'h1;
              if (bitCnt == 4'h7) begin
                bitCnt  <= 4'h0;
                pointer <= pointer + 8'h01;
                state   <= ST_RACK;
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              hostAck <= ~sdaIn;
            end else if (sclFall) begin
              txReg <= rdData;
              state <= hostAck ? ST_RDATA : ST_IDLE;
            end
          end
        endcase
      end
    end
  end

endmodule // sde_serial_port

//--- dv/sde_config_regs_sva.sv
// Port-level assertion checker for the encoder configuration register bank
`timescale 1ns/1ps
module sde_config_regs_sva
  import sde_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // Serial pins
  input wire logic        scl,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  // Decoded settings
  input wire logic        encoderReset,
  input wire logic [2:0]  dacEnable,
  input wire logic        pllEnable,
  input wire logic        rgbInput,
  input wire logic        wideInputBus,
  input wire logic        rgb16Input,
  input wire logic        rgbOutput,
  input wire logic        rgbSyncEmbed,
  input wire logic        componentOutput,
  input wire logic        compositeVideoOutput,
  input wire logic [1:0]  timingMode,
  input wire logic        timingSlave,
  input wire logic        lineStart,
  input wire logic        fieldStart,
  input wire logic [31:0] subcarrierFreq
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_reset_hold_len: assert property ($rose(encoderReset) |-> encoderReset[*8])
    else $error("software reset shorter than 8 cycles");
  a_reset_clears_all: assert property ($fell(encoderReset) |->
      dacEnable == 3'h0 && pllEnable && subcarrierFreq == 32'h0000_0000)
    else $error("settings not cleared by software reset");
  // Settings must also read as cleared one cycle into a software reset
  a_rgb16_from_both: assert property (rgb16Input == (rgbInput && wideInputBus) &&
      (!$past(encoderReset) || !rgb16Input))
    else $error("wide rgb input not the and of its two settings");
  a_rgb_sync_pair: assert property (rgbOutput == rgbSyncEmbed &&
      (!$past(encoderReset) || !rgbOutput))
    else $error("rgb output and its embedded sync differ");
  a_out_exclusive: assert property (componentOutput != compositeVideoOutput &&
      (!$past(encoderReset) || componentOutput))
    else $error("component and composite selected together");
  // Open drain: the pin itself never drives high
  a_sda_open_drain: assert property (sdaOut == 1'b0)
    else $error("serial data pin driven high");
  // Data and ack only change while the serial clock is low
  a_sda_stable_high: assert property (scl[*3] |-> $stable(sdaOe))
    else $error("serial data changed while clock high");
  a_line_one_cycle: assert property (lineStart |=> !lineStart)
    else $error("line start wider than one cycle");
  a_line_only_slave: assert property (lineStart |->
      $past(timingSlave) && $past(timingMode) == 2'h2 && !$past(encoderReset))
    else $error("line start outside slave timing mode 2");
  a_field_only_slave: assert property (fieldStart |->
      $past(timingSlave) && $past(timingMode) == 2'h2 && !$past(encoderReset))
    else $error("field start outside slave timing mode 2");
endmodule // sde_config_regs_sva

bind sde_config_regs sde_config_regs_sva uChk (
  .ref_clk(ref_clk), .nrst(nrst), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .encoderReset(encoderReset), .dacEnable(dacEnable), .pllEnable(pllEnable),
  .rgbInput(rgbInput), .wideInputBus(wideInputBus), .rgb16Input(rgb16Input),
  .rgbOutput(rgbOutput), .rgbSyncEmbed(rgbSyncEmbed), .componentOutput(componentOutput),
  .compositeVideoOutput(compositeVideoOutput), .timingMode(timingMode),
  .timingSlave(timingSlave), .lineStart(lineStart), .fieldStart(fieldStart),
  .subcarrierFreq(subcarrierFreq));

//--- dv/tb_sd_625i_encoder_config_regs.sv
// Self-checking testbench for the encoder configuration register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); fails++; end end
module tb_sd_625i_encoder_config_regs;
  import sde_pkg::*;
  localparam logic [6:0] DEV = 7'h2A;  // Arbitrary value
  logic        ref_clk, nrst, scl, sdaHost, lineSyncN, fieldSyncN;
  logic        sdaOut, sdaOe, encoderReset, pllEnable, rgbInput, wideInputBus, rgb16Input;
  logic        rgbOutput, rgbSyncEmbed, componentOutput, compositeVideoOutput;
  logic        palStandard, lumaShapingFilter, colourDiffShapingFilter, activeEdgeControl;
  logic        pedestalEnable, squarePixel, pixelDataValid, timingSlave, lineStart, fieldStart;
  logic [2:0]  dacEnable, inputMode, chromaFilterSel;
  logic [1:0]  timingMode;
  logic [31:0] subcarrierFreq;
  logic [7:0]  rd;
  logic        k0, k1, k2;
  int          fails, total_checks, lineCnt, fieldCnt, rstCnt;
  logic [7:0]  cfgA [8] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'h82, 8'h87, 8'h88, 8'h8A};
  logic [7:0]  cfgD [8] = '{8'h1C, 8'h00, 8'h10, 8'h11, 8'hC1, 8'h80, 8'h10, 8'h0C};
  logic [7:0]  ocD [4] = '{8'hC1, 8'hC3, 8'hD3, 8'hC9};
  logic [6:0]  ocE [4] = '{7'h6C, 7'h5C, 7'h5D, 7'h6E};
  // Pulled-up data line: low when either side pulls it
  wire         sdaLine = sdaHost & ~sdaOe;

  sde_config_regs #(.DEV_ADDR(DEV)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .lineSyncN(lineSyncN), .fieldSyncN(fieldSyncN),
    .encoderReset(encoderReset), .dacEnable(dacEnable), .pllEnable(pllEnable),
    .inputMode(inputMode), .rgbInput(rgbInput), .wideInputBus(wideInputBus),
    .rgb16Input(rgb16Input), .rgbOutput(rgbOutput), .rgbSyncEmbed(rgbSyncEmbed),
    .componentOutput(componentOutput), .compositeVideoOutput(compositeVideoOutput),
    .palStandard(palStandard), .lumaShapingFilter(lumaShapingFilter),
    .chromaFilterSel(chromaFilterSel), .colourDiffShapingFilter(colourDiffShapingFilter),
    .activeEdgeControl(activeEdgeControl), .pedestalEnable(pedestalEnable),
    .squarePixel(squarePixel), .pixelDataValid(pixelDataValid), .timingMode(timingMode),
    .timingSlave(timingSlave), .lineStart(lineStart), .fieldStart(fieldStart),
    .subcarrierFreq(subcarrierFreq));

  // ==========================================================================
  // Clock, pulse counters, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (lineStart === 1'b1) lineCnt++;
    if (fieldStart === 1'b1) fieldCnt++;
    if (encoderReset === 1'b1) rstCnt++;
  end
  // Whole run is about 9.2k cycles; 60k, over six times that, means a hang
  initial begin
    #(50 * 60000);
    fails++;
    finish_test();
  end

  // ==========================================================================
  // Serial port tasks: each phase lasts 4 cycles, above the 2-cycle minimum
  task automatic ph(input logic s, input logic d);
    @(negedge ref_clk);
    scl = s;
    sdaHost = d;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic i2cStart();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  task automatic i2cStop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, b[i]);
      ph(1'b1, b[i]);
    end
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ack = ~sdaLine;
  endtask
  // Single-byte read, ended by a not-acknowledge
  task automatic rdByte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      b[i] = sdaLine;
    end
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    i2cStart();
    sendByte({DEV, 1'b0}, k0);
    sendByte(a, k1);
    sendByte(d, k2);
    i2cStop();
    `CHK("write acks", 3'h7, {k0, k1, k2})
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    i2cStart();
    sendByte({DEV, 1'b0}, k0);
    sendByte(a, k1);
    i2cStart();
    sendByte({DEV, 1'b1}, k2);
    rdByte(d);
    i2cStop();
    `CHK("read acks", 3'h7, {k0, k1, k2})
  endtask
  task automatic loadFsc(input logic [31:0] w);
    for (int i = 0; i < 4; i++) wrReg(8'h8C + 8'(i), w[8*i +: 8]);
    `CHK("subcarrierFreq", w, subcarrierFreq)
  endtask
  // Falling syncs must give one start pulse each only in slave mode 2
  task automatic syncTest(input logic [7:0] tm, input int ex);
    wrReg(8'h8A, tm);
    lineCnt = 0;
    fieldCnt = 0;
    @(negedge ref_clk);
    lineSyncN = 1'b0;
    fieldSyncN = 1'b0;
    repeat (6) @(negedge ref_clk);
    lineSyncN = 1'b1;
    fieldSyncN = 1'b1;
    `CHK("line pulses", ex, lineCnt)
    `CHK("field pulses", ex, fieldCnt)
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    scl = 1'b1; sdaHost = 1'b1; lineSyncN = 1'b1; fieldSyncN = 1'b1; nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    `CHK("pll at reset", 1'b1, pllEnable)
    // Script order: software reset first; it ends before the next write strobe
    wrReg(8'h17, 8'h02);
    foreach (cfgA[i]) wrReg(cfgA[i], cfgD[i]);
    `CHK("dac and pll", 4'hF, {dacEnable, pllEnable})
    `CHK("inputMode", 3'h0, inputMode)
    `CHK("rgb output", 2'h3, {rgbOutput, rgbSyncEmbed})
    `CHK("standard", 5'h18, {palStandard, lumaShapingFilter, chromaFilterSel})
    `CHK("input select", 3'h7, {rgbInput, wideInputBus, rgb16Input})
    `CHK("timing", 3'h5, {timingMode, timingSlave})
    foreach (cfgA[i]) begin
      rdReg(cfgA[i], rd);
      `CHK("readback", cfgD[i], rd)
    end
    // Output control: component, composite, square pixels, component with pedestal
    foreach (ocD[i]) begin
      wrReg(8'h82, ocD[i]);
      `CHK("output control", ocE[i], {pixelDataValid, componentOutput, compositeVideoOutput,
        colourDiffShapingFilter, activeEdgeControl, pedestalEnable, squarePixel})
    end
    loadFsc(32'h2A09_8ACB);
    loadFsc(32'h2679_8C0C);
    syncTest(8'h00, 0);
    syncTest(8'h0C, 1);
    // Unmapped place reads back zero; foreign device address gets no ack
    wrReg(8'h40, 8'h5A);
    rdReg(8'h40, rd);
    `CHK("unmapped read", 8'h00, rd)
    i2cStart();
    sendByte(8'h56, k0);
    i2cStop();
    `CHK("foreign address ack", 1'b0, k0)
    rstCnt = 0;
    wrReg(8'h17, 8'h02);
    repeat (12) @(negedge ref_clk);
    `CHK("reset length", SOFT_RESET_CYCLES, rstCnt)
    `CHK("cleared dac and pll", 4'h1, {dacEnable, pllEnable})
    `CHK("cleared subcarrier", 32'h0000_0000, subcarrierFreq)
    finish_test();
  end
endmodule // tb_sd_625i_encoder_config_regs
